// ===== conv_cmd_consts.vh
// Command codes, fields, defaults and timing for the converter command block
`ifndef CONV_CMD_CONSTS_VH
`define CONV_CMD_CONSTS_VH
`define CMD_ON_CTRL  8'h01
`define CMD_CFG      8'h02
`define CMD_CLR      8'h03
`define CMD_LOCK     8'h10
`define CMD_SAVE     8'h11
`define CMD_LOAD     8'h12
`define CMD_FEAT     8'h19
`define CMD_FMT      8'h20
`define CMD_SET      8'h21
`define CMD_TRIM     8'h23
`define CMD_CEIL     8'h24
`define CMD_RATE     8'h27
`define OP_EN        7
`define OP_SOFT      6
`define OP_ALRT_HI   3
`define OP_ALRT_LO   2
`define ALRT_ON      2'h2
`define CFG_PWRUP    4
`define CFG_CMD      3
`define CFG_PIN      2
`define CFG_POL      1
`define LOCK_ALL     8'h80
`define LOCK_OP      8'h40
`define LOCK_CTRL    8'h20
`define LOCK_NONE    8'h00
`define FEAT_VAL     8'h30
`define FMT_VAL      8'h14
`define DEF_OP       8'h88
`define DEF_CFG      8'h1A
`define DEF_LOCK     8'h00
`define DEF_SET      16'hC000
`define DEF_TRIM     16'h0000
`define DEF_CEIL     16'hD000
`define DEF_RATE     16'h0010
`define RD_NONE      16'hFFFF
`define SYNC_RST     5'h03
`define NB_SEND      3'h2
`define NB_BYTE      3'h3
`define NB_WORD      3'h4
`define NB_MAX       3'h7
`define BIT_LAST     4'h8
`define CLK_MHZ      250
`define OFF_DELAY_US 1000
`define RAMP_TICK_US 1000
`endif

// ===== conv_cmd.v
// Converter command handler with PMBus slave on sampled pins
// Operation
// - Control bit 7 turns output on/off
// - Soft-off bit delays shutdown, else immediate
// - Control bits 3:2 enable or mute alert
// - Config bit 4 picks power-up start policy
// - Config bit 3 lets command start output
// - Config bit 2 lets remote pin control
// - Config bit 1 sets pin polarity
// - Fault-clear command clears all latched faults
// - Lock 0x80 allows only lock writes
// - Lock 0x40 allows lock and control
// - Lock 0x20 adds config and setpoint
// - Lock 0x00 allows every write
// - Save command copies configuration to store
// - Load command reloads configuration from store
// - Feature byte reports PEC and speed
// - Feature bit 4 reports alert present
// - Format byte is unsigned linear, N=-12
// - Setpoint applied only at restart, not sharing
// - Trim adds bias to output setting
// - Setpoint over ceiling clamps and alerts
// - Over-ceiling level slews back at rate
// - Alert low while fault persists
`timescale 1ns/10ps
`include "conv_cmd_consts.vh"
module conv_cmd #(
    parameter [6:0] BUS_ADDR      = 7'h58,
    parameter       CNT_W         = 18,
    parameter       OFF_DELAY_CYC = `OFF_DELAY_US * `CLK_MHZ,
    parameter       RAMP_TICK_CYC = `RAMP_TICK_US * `CLK_MHZ
) (
    input  wire        clk,
    input  wire        rst_b,
    input  wire        scl_in,
    input  wire        sda_in,
    output reg         sda_out,
    output reg         sda_oe,
    input  wire        ctrl_pin,
    input  wire        fault_in,
    input  wire        sharing_active,
    output reg         output_on,
    output reg  [15:0] vout_level,
    output reg         fault_alert_line_out,
    output reg         fault_alert_line_oe
);

localparam [2:0] ST_IDLE = 3'h0;
localparam [2:0] ST_RX   = 3'h1;
localparam [2:0] ST_ACK  = 3'h2;
localparam [2:0] ST_TX   = 3'h3;
localparam [2:0] ST_TXA  = 3'h4;

// Lock level decode
function wr_allowed;
    input [7:0] lock;
    input [7:0] cmd;
    begin
        case (lock)
            `LOCK_NONE: wr_allowed = 1'b1;
            `LOCK_CTRL: wr_allowed = (cmd == `CMD_LOCK) |
                (cmd == `CMD_ON_CTRL) | (cmd == `CMD_CFG) |
                (cmd == `CMD_SET);
            `LOCK_OP: wr_allowed = (cmd == `CMD_LOCK) |
                (cmd == `CMD_ON_CTRL);
            default: wr_allowed = (cmd == `CMD_LOCK);
        endcase
    end
endfunction

// Three-stage sampling: scl, sda, pin, fault, sharing
reg  [4:0] sy1_q;
reg  [4:0] sy2_q;
reg  [4:0] sy3_q;
reg  [4:0] flt_q;
reg  [4:0] prv_q;

always @(posedge clk or negedge rst_b)
begin
    if (!rst_b)
    begin
        sy1_q <= `SYNC_RST;
        sy2_q <= `SYNC_RST;
        sy3_q <= `SYNC_RST;
        flt_q <= `SYNC_RST;
        prv_q <= `SYNC_RST;
    end
    else
    begin
        sy1_q <= {sharing_active, fault_in, ctrl_pin, sda_in, scl_in};
        sy2_q <= sy1_q;
        sy3_q <= sy2_q;
        // Change taken only once stages two and three agree
        flt_q <= (sy2_q & sy3_q) | (flt_q & (sy2_q ^ sy3_q));
        prv_q <= flt_q;
    end
end

wire scl     = flt_q[0];
wire sda     = flt_q[1];
wire pin_raw = flt_q[2];
wire flt_now = flt_q[3];
wire share   = flt_q[4];
wire scl_r   = scl & ~prv_q[0];
wire scl_f   = ~scl & prv_q[0];
wire bus_st  = scl & prv_q[0] & ~sda & prv_q[1];
wire bus_sp  = scl & prv_q[0] & sda & ~prv_q[1];

// Working configuration
reg  [7:0]  op_q;
reg  [7:0]  cfg_q;
reg  [7:0]  lock_q;
reg  [15:0] set_q;
reg  [15:0] trim_q;
reg  [15:0] ceil_q;
reg  [15:0] rate_q;

// Serial engine
reg  [2:0]  st_q;
reg  [3:0]  cnt_q;
reg  [7:0]  sh_q;
reg  [2:0]  nb_q;
reg         rd_q;
reg  [7:0]  cmd_q;
reg  [7:0]  wlo_q;
reg  [7:0]  whi_q;
reg  [7:0]  tx_q;
reg         txi_q;
reg  [15:0] rd_word;

always @*
begin
    case (cmd_q)
        `CMD_ON_CTRL: rd_word = {8'h00, op_q};
        `CMD_CFG:     rd_word = {8'h00, cfg_q};
        `CMD_LOCK:    rd_word = {8'h00, lock_q};
        `CMD_FEAT:    rd_word = {8'h00, `FEAT_VAL};
        `CMD_FMT:     rd_word = {8'h00, `FMT_VAL};
        `CMD_SET:     rd_word = set_q;
        `CMD_TRIM:    rd_word = trim_q;
        `CMD_CEIL:    rd_word = ceil_q;
        `CMD_RATE:    rd_word = rate_q;
        default:      rd_word = `RD_NONE;
    endcase
end

wire [7:0] rd_lo = rd_word[7:0];
wire [7:0] rd_hi = rd_word[15:8];

always @(posedge clk or negedge rst_b)
begin
    if (!rst_b)
    begin
        st_q    <= ST_IDLE;
        cnt_q   <= 4'h0;
        sh_q    <= 8'h00;
        nb_q    <= 3'h0;
        rd_q    <= 1'b0;
        cmd_q   <= 8'h00;
        wlo_q   <= 8'h00;
        whi_q   <= 8'h00;
        tx_q    <= 8'h00;
        txi_q   <= 1'b0;
        sda_oe  <= 1'b0;
        sda_out <= 1'b0;
    end
    else if (bus_st)
    begin
        st_q   <= ST_RX;
        cnt_q  <= 4'h0;
        nb_q   <= 3'h0;
        rd_q   <= 1'b0;
        sda_oe <= 1'b0;
    end
    else if (bus_sp)
    begin
        st_q   <= ST_IDLE;
        sda_oe <= 1'b0;
    end
    else
    begin
        case (st_q)
            ST_RX:
            begin
                if (scl_r)
                begin
                    sh_q  <= {sh_q[6:0], sda};
                    cnt_q <= cnt_q + 4'h1;
                end
                else if (scl_f && cnt_q == `BIT_LAST)
                begin
                    if (nb_q == 3'h0 && sh_q[7:1] != BUS_ADDR)
                        st_q <= ST_IDLE;
                    else
                    begin
                        if (nb_q == 3'h0)
                            rd_q <= sh_q[0];
                        if (nb_q == 3'h1)
                            cmd_q <= sh_q;
                        if (nb_q == 3'h2)
                            wlo_q <= sh_q;
                        if (nb_q == 3'h3)
                            whi_q <= sh_q;
                        if (nb_q != `NB_MAX)
                            nb_q <= nb_q + 3'h1;
                        sda_oe <= 1'b1;
                        st_q   <= ST_ACK;
                    end
                end
            end
            ST_ACK:
            begin
                if (scl_f)
                begin
                    if (rd_q)
                    begin
                        // Word read sends low byte first
                        tx_q   <= rd_lo;
                        txi_q  <= 1'b1;
                        sda_oe <= ~rd_lo[7];
                        cnt_q  <= 4'h1;
                        st_q   <= ST_TX;
                    end
                    else
                    begin
                        sda_oe <= 1'b0;
                        cnt_q  <= 4'h0;
                        st_q   <= ST_RX;
                    end
                end
            end
            ST_TX:
            begin
                if (scl_f)
                begin
                    if (cnt_q == `BIT_LAST)
                    begin
                        sda_oe <= 1'b0;
                        st_q   <= ST_TXA;
                    end
                    else
                    begin
                        tx_q   <= {tx_q[6:0], 1'b0};
                        sda_oe <= ~tx_q[6];
                        cnt_q  <= cnt_q + 4'h1;
                    end
                end
            end
            ST_TXA:
            begin
                // Host nack ends the read; extra acks resend high byte
                if (scl_r && sda)
                    st_q <= ST_IDLE;
                else if (scl_f)
                begin
                    tx_q   <= rd_hi;
                    sda_oe <= ~rd_hi[7];
                    cnt_q  <= 4'h1;
                    st_q   <= ST_TX;
                end
            end
            default:
                st_q <= ST_IDLE;
        endcase
    end
end

// Write commit at stop; size must match the command
wire is_send = (cmd_q == `CMD_CLR) | (cmd_q == `CMD_SAVE) |
               (cmd_q == `CMD_LOAD);
wire is_byte = (cmd_q == `CMD_ON_CTRL) | (cmd_q == `CMD_CFG) |
               (cmd_q == `CMD_LOCK);
wire is_word = (cmd_q == `CMD_SET) | (cmd_q == `CMD_TRIM) |
               (cmd_q == `CMD_CEIL) | (cmd_q == `CMD_RATE);
wire wr_go   = bus_sp & (st_q != ST_IDLE) & ~rd_q &
               (nb_q >= `NB_SEND);
wire w_ok    = wr_allowed(lock_q, cmd_q) &
               ((is_send & nb_q == `NB_SEND) |
                (is_byte & nb_q == `NB_BYTE) |
                (is_word & nb_q == `NB_WORD));
wire go_ok   = wr_go & w_ok;
wire go_bad  = wr_go & ~w_ok;
wire [15:0] wdat = {whi_q, wlo_q};
wire clr     = go_ok & (cmd_q == `CMD_CLR);
wire ceil_hit = go_ok & (cmd_q == `CMD_SET) & (wdat > ceil_q);

// Default store
reg  [7:0]  nv_op_q;
reg  [7:0]  nv_cfg_q;
reg  [7:0]  nv_lock_q;
reg  [15:0] nv_set_q;
reg  [15:0] nv_trim_q;
reg  [15:0] nv_ceil_q;
reg  [15:0] nv_rate_q;

always @(posedge clk or negedge rst_b)
begin
    if (!rst_b)
    begin
        op_q      <= `DEF_OP;
        cfg_q     <= `DEF_CFG;
        lock_q    <= `DEF_LOCK;
        set_q     <= `DEF_SET;
        trim_q    <= `DEF_TRIM;
        ceil_q    <= `DEF_CEIL;
        rate_q    <= `DEF_RATE;
        nv_op_q   <= `DEF_OP;
        nv_cfg_q  <= `DEF_CFG;
        nv_lock_q <= `DEF_LOCK;
        nv_set_q  <= `DEF_SET;
        nv_trim_q <= `DEF_TRIM;
        nv_ceil_q <= `DEF_CEIL;
        nv_rate_q <= `DEF_RATE;
    end
    else if (go_ok)
    begin
        case (cmd_q)
            `CMD_ON_CTRL: op_q   <= wlo_q;
            `CMD_CFG:     cfg_q  <= wlo_q;
            `CMD_LOCK:    lock_q <= wlo_q;
            `CMD_SET:     set_q  <= wdat;
            `CMD_TRIM:    trim_q <= wdat;
            `CMD_CEIL:    ceil_q <= wdat;
            `CMD_RATE:    rate_q <= wdat;
            `CMD_SAVE:
            begin
                nv_op_q   <= op_q;
                nv_cfg_q  <= cfg_q;
                nv_lock_q <= lock_q;
                nv_set_q  <= set_q;
                nv_trim_q <= trim_q;
                nv_ceil_q <= ceil_q;
                nv_rate_q <= rate_q;
            end
            `CMD_LOAD:
            begin
                op_q   <= nv_op_q;
                cfg_q  <= nv_cfg_q;
                lock_q <= nv_lock_q;
                set_q  <= nv_set_q;
                trim_q <= nv_trim_q;
                ceil_q <= nv_ceil_q;
                rate_q <= nv_rate_q;
            end
            default:
                op_q <= op_q;
        endcase
    end
end

// Latched faults; a new event beats a clear in the same cycle
reg flt_lat_q;
reg cml_q;
reg ceil_q_flt;

always @(posedge clk or negedge rst_b)
begin
    if (!rst_b)
    begin
        flt_lat_q  <= 1'b0;
        cml_q      <= 1'b0;
        ceil_q_flt <= 1'b0;
    end
    else
    begin
        flt_lat_q  <= flt_now | (flt_lat_q & ~clr);
        cml_q      <= go_bad | (cml_q & ~clr);
        ceil_q_flt <= ceil_hit | (ceil_q_flt & ~clr);
    end
end

wire alrt_en = (op_q[`OP_ALRT_HI:`OP_ALRT_LO] == `ALRT_ON);
wire any_flt = flt_now | flt_lat_q | cml_q | ceil_q_flt;

always @(posedge clk or negedge rst_b)
begin
    if (!rst_b)
    begin
        fault_alert_line_oe  <= 1'b0;
        fault_alert_line_out <= 1'b0;
    end
    else
    begin
        // Drives low only; released after clear when clean
        fault_alert_line_oe  <= alrt_en & any_flt;
        fault_alert_line_out <= 1'b0;
    end
end

// Output enable policy
wire pin_act = cfg_q[`CFG_POL] ? pin_raw : ~pin_raw;
wire want    = (~cfg_q[`CFG_PWRUP] | cfg_q[`CFG_CMD] |
                cfg_q[`CFG_PIN]) &
               (~cfg_q[`CFG_CMD] | op_q[`OP_EN]) &
               (~cfg_q[`CFG_PIN] | pin_act);

reg [CNT_W-1:0] off_cnt_q;
reg [15:0]      app_q;

always @(posedge clk or negedge rst_b)
begin
    if (!rst_b)
    begin
        output_on <= 1'b0;
        off_cnt_q <= {CNT_W{1'b0}};
        app_q     <= `DEF_SET;
    end
    else if (want)
    begin
        output_on <= 1'b1;
        off_cnt_q <= {CNT_W{1'b0}};
        // New setpoint only taken at a start outside sharing
        if (!output_on && !share)
            app_q <= set_q;
    end
    else if (output_on)
    begin
        if (op_q[`OP_SOFT] &&
            off_cnt_q != OFF_DELAY_CYC[CNT_W-1:0] - 1'b1)
            off_cnt_q <= off_cnt_q + 1'b1;
        else
            output_on <= 1'b0;
    end
end

// Target: applied setpoint plus trim, held under the ceiling
wire [16:0] sum = {1'b0, app_q} + {1'b0, trim_q};
wire [15:0] tgt = (sum > {1'b0, ceil_q}) ? ceil_q : sum[15:0];

reg [CNT_W-1:0] tick_q;
wire tick = (tick_q == RAMP_TICK_CYC[CNT_W-1:0] - 1'b1);

always @(posedge clk or negedge rst_b)
begin
    if (!rst_b)
    begin
        tick_q     <= {CNT_W{1'b0}};
        vout_level <= 16'h0000;
    end
    else
    begin
        tick_q <= tick ? {CNT_W{1'b0}} : tick_q + 1'b1;
        // One rate step per tick; zero rate freezes the level
        if (tick && vout_level > tgt)
            vout_level <= (vout_level - tgt > rate_q) ?
                vout_level - rate_q : tgt;
        else if (tick && vout_level < tgt)
            vout_level <= (tgt - vout_level > rate_q) ?
                vout_level + rate_q : tgt;
    end
end

endmodule // conv_cmd

// ===== conv_cmd_assertions.sv
// Port checker for the converter command block
`timescale 1ns/10ps
module conv_cmd_checker #(
    parameter RAMP_TICK_CYC = 8
) (
    input wire        clk,
    input wire        rst_b,
    input wire        scl_in,
    input wire        fault_in,
    input wire        sda_out,
    input wire        sda_oe,
    input wire        output_on,
    input wire [15:0] vout_level,
    input wire        fault_alert_line_out,
    input wire        fault_alert_line_oe
);
    reg [15:0] gap_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // Cycles since the level last moved
    always @(posedge clk or negedge rst_b)
        if (!rst_b)
            gap_q <= 16'h0000;
        else if ($changed(vout_level))
            gap_q <= 16'h0000;
        else if (gap_q != 16'hFFFF)
            gap_q <= gap_q + 16'h0001;

    reset_state_a: assert property (
        $rose(rst_b) |-> !output_on && !sda_oe && !fault_alert_line_oe)
        else $error("outputs not quiet after reset");
    on_change_a: assert property (
        $changed(output_on) |-> scl_in)
        else $error("output enable moved mid-transfer");
    drive_low_a: assert property (
        !sda_out && !fault_alert_line_out)
        else $error("open-drain pin driven high");
    alert_hold_a: assert property (
        fault_in [*6] ##0 fault_alert_line_oe ##0 !scl_in
        |=> fault_alert_line_oe)
        else $error("alert released while fault persists");
    alert_drop_a: assert property (
        $fell(fault_alert_line_oe) |-> scl_in)
        else $error("alert released mid-transfer");
    // One cycle of slack for the tick phase at reset release
    ramp_pace_a: assert property (
        $changed(vout_level) && $past(output_on) && output_on
        |-> gap_q >= RAMP_TICK_CYC - 2)
        else $error("level moved faster than one step per tick");
    ack_release_a: assert property (
        $rose(sda_oe) |-> ##[1:400] !sda_oe)
        else $error("data pin held low too long");
    sda_timing_a: assert property (
        $changed(sda_oe) |-> !scl_in)
        else $error("data pin changed while bus clock high");

    cover property (fault_alert_line_oe && fault_in);
    cover property ($fell(output_on));
    cover property ($rose(sda_oe));
endmodule // conv_cmd_checker

bind conv_cmd conv_cmd_checker #(.RAMP_TICK_CYC(RAMP_TICK_CYC)) chk (
    .clk(clk), .rst_b(rst_b), .scl_in(scl_in), .fault_in(fault_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .output_on(output_on),
    .vout_level(vout_level), .fault_alert_line_out(fault_alert_line_out),
    .fault_alert_line_oe(fault_alert_line_oe));

// ===== pmbus_host.sv
// PMBus host model driving the command block's bus pins
`timescale 1ns/10ps
module pmbus_host #(
    parameter [6:0] ADDR = 7'h58
) (
    input  wire        clk,
    input  wire        sda_line,
    output reg         scl,
    output reg         sda_low,
    output reg         rd_valid,
    output reg  [15:0] rd_data
);
    reg [7:0] q;
    reg [7:0] lo;
    reg       a;

    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
        rd_valid = 1'b0;
        rd_data = 16'h0000;
    end
    task wt(input integer n);
        repeat (n) @(posedge clk);
    endtask
    // Phases of 8 clk so the 3-flop sampler never misses an edge
    task bit_x(input b, output r);
        wt(4);
        sda_low <= !b;
        wt(4);
        scl <= 1'b1;
        wt(8);
        r = sda_line;
        scl <= 1'b0;
    endtask
    task byte_x(input [7:0] d, input last);
        integer i;
        for (i = 7; i >= 0; i = i - 1)
            bit_x(d[i], q[i]);
        bit_x(last, a);
    endtask
    task start;
        wt(4);
        sda_low <= 1'b0;
        wt(4);
        scl <= 1'b1;
        wt(8);
        sda_low <= 1'b1;
        wt(8);
        scl <= 1'b0;
    endtask
    task stop;
        wt(4);
        sda_low <= 1'b1;
        wt(4);
        scl <= 1'b1;
        wt(8);
        sda_low <= 1'b0;
        wt(8);
    endtask
    task head(input [7:0] cmd);
        start;
        byte_x({ADDR, 1'b0}, 1'b1);
        byte_x(cmd, 1'b1);
    endtask
    // Low byte first; n is the count of data bytes
    task wr(input [7:0] cmd, input integer n, input [15:0] d);
        head(cmd);
        if (n > 0)
            byte_x(d[7:0], 1'b1);
        if (n > 1)
            byte_x(d[15:8], 1'b1);
        stop;
    endtask
    task rd(input [7:0] cmd, input integer n);
        head(cmd);
        start;
        byte_x({ADDR, 1'b1}, 1'b1);
        byte_x(8'hFF, n < 2);
        lo = q;
        if (n > 1)
            byte_x(8'hFF, 1'b1);
        else
            q = 8'h00;
        stop;
        rd_data <= {q, lo};
        rd_valid <= 1'b1;
        wt(1);
        rd_valid <= 1'b0;
    endtask
endmodule // pmbus_host

// ===== test_converter_pmbus_control_commands.sv
// Self-checking bench for the converter command block
`timescale 1ns/10ps
`include "conv_cmd_consts.vh"
module test_converter_pmbus_control_commands;
    localparam [179:0] TBL = {20'h881A1, 20'h881A3, 20'h881C1, 20'h881C2,
        20'h881E3, 20'h881E0, 20'h08080, 20'h08001, 20'h081A0};
    reg         clk;
    reg         rst_b;
    reg         ctrl_pin;
    reg         fault_in;
    reg         sharing_active;
    wire        scl;
    wire        sda_low;
    wire        sda_oe;
    wire        sda_w;
    wire        output_on;
    wire [15:0] vout_level;
    wire        alert_oe;
    wire        sda_o;
    wire        al_o;
    wire        rd_valid;
    wire [15:0] rd_data;
    integer     fail_count;
    integer     compares;
    integer     seed;
    integer     i;
    reg  [15:0] exp_q[$];
    reg  [15:0] sp;
    reg  [15:0] tr;
    reg  [15:0] v;
    reg  [7:0]  lk;
    reg  [19:0] row;

    // Open-drain bus: high unless someone pulls it
    assign sda_w = !(sda_oe | sda_low);
    conv_cmd #(.OFF_DELAY_CYC(20), .RAMP_TICK_CYC(8)) uut (
        .clk(clk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda_w),
        .sda_out(sda_o), .sda_oe(sda_oe), .ctrl_pin(ctrl_pin),
        .fault_in(fault_in), .sharing_active(sharing_active),
        .output_on(output_on), .vout_level(vout_level),
        .fault_alert_line_out(al_o), .fault_alert_line_oe(alert_oe));
    pmbus_host host (.clk(clk), .sda_line(sda_w), .scl(scl),
        .sda_low(sda_low), .rd_valid(rd_valid), .rd_data(rd_data));

    task test_done;
        $display("fail_count %0d compares %0d", fail_count, compares);
        if (fail_count == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task chk(input [15:0] got, input [15:0] exp);
        compares = compares + 1;
        if (got !== exp)
        begin
            fail_count = fail_count + 1;
            $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
        end
    endtask
    task chk_lvl(input got, input exp);
        chk({15'h0000, got}, {15'h0000, exp});
    endtask
    task rd(input [7:0] c, input integer n, input [15:0] e);
        exp_q.push_back(e);
        host.rd(c, n);
    endtask
    task wr6(input [7:0] c, input integer n, input [15:0] d);
        host.wr(c, n, d);
        host.wt(6);
    endtask

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk)
        if (rd_valid === 1'b1)
            chk(rd_data, exp_q.pop_front());
    initial
    begin
        #400000;
        fail_count = fail_count + 1;
        test_done;
    end

    initial
    begin
        rst_b = 1'b0;
        ctrl_pin = 1'b0;
        fault_in = 1'b0;
        sharing_active = 1'b0;
        fail_count = 0;
        compares = 0;
        seed = 32'h84FA;
        sp = 16'hC000;
        tr = 16'h0000;
        host.wt(2);
        rst_b <= 1'b1;
        host.wt(4);
        chk_lvl(output_on, 1'b1);
        rd(`CMD_FEAT, 1, 16'h0030);
        rd(`CMD_FMT, 1, 16'h0014);
        for (i = 0; i < 9; i = i + 1)
        begin
            row = TBL[i*20 +: 20];
            wr6(`CMD_ON_CTRL, 1, {8'h00, row[19:12]});
            wr6(`CMD_CFG, 1, {8'h00, row[11:4]});
            ctrl_pin <= row[1];
            host.wt(10);
            chk_lvl(output_on, row[0]);
        end
        wr6(`CMD_ON_CTRL, 1, 16'h00C8);
        host.wr(`CMD_ON_CTRL, 1, 16'h0048);
        host.wt(5);
        chk_lvl(output_on, 1'b1);
        host.wt(30);
        chk_lvl(output_on, 1'b0);
        wr6(`CMD_ON_CTRL, 1, 16'h0088);
        wr6(`CMD_CLR, 0, 16'h0000);
        fault_in <= 1'b1;
        host.wt(10);
        chk_lvl(alert_oe, 1'b1);
        wr6(`CMD_ON_CTRL, 1, 16'h0084);
        chk_lvl(alert_oe, 1'b0);
        fault_in <= 1'b0;
        wr6(`CMD_ON_CTRL, 1, 16'h0088);
        chk_lvl(alert_oe, 1'b1);
        wr6(`CMD_CLR, 0, 16'h0000);
        chk_lvl(alert_oe, 1'b0);
        for (i = 0; i < 4; i = i + 1)
        begin
            lk = (i == 3) ? 8'h00 : (8'h80 >> i);
            v = $random(seed) & 16'h7FFF;
            host.wr(`CMD_LOCK, 1, {8'h00, lk});
            host.wr(`CMD_SET, 2, v);
            wr6(`CMD_TRIM, 2, v & 16'h00FF);
            if (lk == 8'h20 || lk == 8'h00)
                sp = v;
            if (lk == 8'h00)
                tr = v & 16'h00FF;
            chk_lvl(alert_oe, lk != 8'h00);
            rd(`CMD_LOCK, 1, {8'h00, lk});
            rd(`CMD_SET, 2, sp);
            rd(`CMD_TRIM, 2, tr);
            host.wr(`CMD_LOCK, 1, 16'h0000);
            host.wr(`CMD_CLR, 0, 16'h0000);
        end
        host.wr(`CMD_TRIM, 2, 16'h0055);
        host.wr(`CMD_SAVE, 0, 16'h0000);
        host.wr(`CMD_TRIM, 2, 16'h0011);
        host.wr(`CMD_LOAD, 0, 16'h0000);
        rd(`CMD_TRIM, 2, 16'h0055);
        host.wr(`CMD_RATE, 2, 16'h1000);
        host.wr(`CMD_CEIL, 2, 16'h1000);
        // Setpoint request above the ceiling raises the alert
        host.wr(`CMD_SET, 2, 16'h2000);
        host.wt(200);
        chk(vout_level, 16'h1000);
        chk_lvl(alert_oe, 1'b1);
        // Restart during sharing keeps the old applied setpoint
        sharing_active <= 1'b1;
        wr6(`CMD_SET, 2, 16'h0800);
        wr6(`CMD_ON_CTRL, 1, 16'h0008);
        chk_lvl(output_on, 1'b0);
        wr6(`CMD_ON_CTRL, 1, 16'h0088);
        host.wt(50);
        chk(vout_level, 16'h1000);
        sharing_active <= 1'b0;
        wr6(`CMD_ON_CTRL, 1, 16'h0008);
        wr6(`CMD_ON_CTRL, 1, 16'h0088);
        host.wt(50);
        chk(vout_level, 16'h0855);
        chk_lvl(sda_o, 1'b0);
        chk_lvl(al_o, 1'b0);
        test_done;
    end
endmodule // test_converter_pmbus_control_commands
